// ===== core/i2csw_pkg.sv
// Shared constants and types for the channel-switch control logic and its bus master
// How it works
// R1 - Master sends address and direction after START
// R2 - Address last bit: 1 read, 0 write
// R3 - Written data byte lands in control register
// R4 - Several written bytes: the last one stays
// R5 - Control register is writable and readable
// R6 - Low bit n set enables channel n
// R7 - New channel selection applies only at STOP
// R8 - Any channel combination may be enabled
// R9 - Long enough reset pin low clears everything (the alert output is not cleared and keeps following the inputs)
// R10 - Alert output low when any input low
// R11 - Alerts detected whether channel selected or not
// R12 - Bits 4 to 7 show channel 0 to 3 alerts
// R13 - Alert bits sampled when register is read
// R14 - Status bit reads 1 when input asserted
// R15 - Master reads status, selects channel, clears devices
// R16 - Alert inputs double as general purpose inputs
// R17 - Reset leaves register zero, channels deselected
// R18 - Addressed receiver acknowledges every byte low
// R19 - Respond only when address pins match
// R20 - Written upper four bits are ignored
package i2csw_pkg;
    // ---------------------------------------------------------------
    // Timing
    // ---------------------------------------------------------------
    localparam int CLK_FREQ_MHZ      = 125;
    localparam int RESET_LOW_MIN_NS  = 500;
    localparam int RESET_LOW_MIN_CYC = (RESET_LOW_MIN_NS * CLK_FREQ_MHZ + 999) / 1000;
    localparam int SCL_PERIOD_NS     = 2500;
    localparam int SCL_QUARTER_CYC   = SCL_PERIOD_NS * CLK_FREQ_MHZ / 4000;
    // ---------------------------------------------------------------
    // Device address and control register layout
    // ---------------------------------------------------------------
    localparam logic [4:0] ADDR_FIXED_HI = 5'h0E;
    localparam logic       RW_READ       = 1'b1;
    localparam int         CHAN_N        = 4;
    localparam logic [3:0] CTRL_RESET    = 4'h0;
    // ---------------------------------------------------------------
    // Master command port map
    // ---------------------------------------------------------------
    localparam logic [1:0] HREG_SLAVE    = 2'h0;
    localparam logic [1:0] HREG_DATA     = 2'h1;
    localparam logic [1:0] HREG_CMD      = 2'h2;
    localparam logic [1:0] HREG_STAT     = 2'h3;
    localparam int         CMD_GO_BIT    = 0;
    localparam int         CMD_READ_BIT  = 1;
    // ---------------------------------------------------------------
    // State types
    // ---------------------------------------------------------------
    typedef enum logic [2:0] {
        DEV_IDLE  = 3'b000,
        DEV_ADDR  = 3'b001,
        DEV_AACK  = 3'b010,
        DEV_WR    = 3'b011,
        DEV_WACK  = 3'b100,
        DEV_RD    = 3'b101,
        DEV_RACK  = 3'b110
    } i2csw_dev_state_e;
    typedef enum logic [1:0] {
        HST_IDLE  = 2'b00,
        HST_START = 2'b01,
        HST_BIT   = 2'b10,
        HST_STOP  = 2'b11
    } i2csw_hst_state_e;
endpackage

// ===== core/i2csw_if.sv
// Two-wire link between the bus master and the channel switch
`timescale 1ns/100ps
`default_nettype none
interface i2csw_if;
    logic sclHostOut;
    logic sclHostOe;
    logic sdaHostOut;
    logic sdaHostOe;
    logic sdaDevOut;
    logic sdaDevOe;
    logic sclLine;
    logic sdaLine;
    // Open-drain wired AND with pull-ups
    assign sclLine = !(sclHostOe && !sclHostOut);
    assign sdaLine = !((sdaHostOe && !sdaHostOut) || (sdaDevOe && !sdaDevOut));
    modport dev  (input sclLine, input sdaLine, output sdaDevOut, output sdaDevOe);
    modport host (input sclLine, input sdaLine, output sclHostOut, output sclHostOe,
                  output sdaHostOut, output sdaHostOe);
endinterface
`default_nettype wire

// ===== core/i2csw_sync.sv
// Two-flop synchroniser for pins from outside the clock domain
`timescale 1ns/100ps
`default_nettype none
module i2csw_sync #(
    parameter int               WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT  = '1
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             reset,
    // Pins in, synchronised out
    input  wire logic [WIDTH-1:0] pinIn,
    output logic      [WIDTH-1:0] syncOut_q
);
    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge clk) begin
        if (reset) begin
            meta_q    <= INIT;
            syncOut_q <= INIT;
        end else begin
            meta_q    <= pinIn;
            syncOut_q <= meta_q;
        end
    end
endmodule
`default_nettype wire

// ===== core/i2csw_device.sv
// Serial-bus slave control logic of the four-channel switch
`timescale 1ns/100ps
`default_nettype none
module i2csw_device
    import i2csw_pkg::*;
(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              reset,
    // Upstream link
    i2csw_if.dev                   link,
    // Straps and reset pin
    input  wire logic              addr_select_pin_lo,
    input  wire logic              addr_select_pin_hi,
    input  wire logic              extResetN,
    // Channel alert inputs, active low
    input  wire logic              chan0_alert_in_n,
    input  wire logic              chan1_alert_in_n,
    input  wire logic              chan2_alert_in_n,
    input  wire logic              chan3_alert_in_n,
    // Open-drain alert output
    output logic                   alertOut,
    output logic                   alertOutOe,
    // Connected channels
    output logic [CHAN_N-1:0]      activeChan_q
);
    // ---------------------------------------------------------------
    // Pin synchronisers
    // ---------------------------------------------------------------
    logic [8:0]        pinsS;
    logic              sclS;
    logic              sdaS;
    logic              addrLoS;
    logic              addrHiS;
    logic              extResetNS;
    logic [CHAN_N-1:0] alertNS;

    i2csw_sync #(.WIDTH(9), .INIT(9'h1FF)) u_sync (
        .clk       (clk),
        .reset     (reset),
        .pinIn     ({link.sclLine, link.sdaLine, addr_select_pin_lo, addr_select_pin_hi,
                     extResetN, chan3_alert_in_n, chan2_alert_in_n, chan1_alert_in_n,
                     chan0_alert_in_n}),
        .syncOut_q (pinsS)
    );

    assign sclS       = pinsS[8];
    assign sdaS       = pinsS[7];
    assign addrLoS    = pinsS[6];
    assign addrHiS    = pinsS[5];
    assign extResetNS = pinsS[4];
    assign alertNS    = pinsS[3:0];

    // ---------------------------------------------------------------
    // Reset pin qualification
    // ---------------------------------------------------------------
    // A glitch shorter than the minimum pulse is ignored
    logic [15:0] rstCnt_q;
    logic        pinReset;
    logic        clear;

    assign pinReset = (rstCnt_q == 16'(RESET_LOW_MIN_CYC));
    assign clear    = reset || pinReset; // R9 R17

    always_ff @(posedge clk) begin
        if (reset || extResetNS) begin
            rstCnt_q <= 16'h0000;
        end else if (!pinReset) begin
            rstCnt_q <= rstCnt_q + 16'h0001; // R9
        end
    end

    // ---------------------------------------------------------------
    // Bus condition detection
    // ---------------------------------------------------------------
    logic sclP_q;
    logic sdaP_q;
    logic sclRise;
    logic sclFall;
    logic startCond;
    logic stopCond;

    always_ff @(posedge clk) begin
        if (reset) begin
            sclP_q <= 1'b1;
            sdaP_q <= 1'b1;
        end else begin
            sclP_q <= sclS;
            sdaP_q <= sdaS;
        end
    end

    assign sclRise   = sclS && !sclP_q;
    assign sclFall   = !sclS && sclP_q;
    assign startCond = sclS && sclP_q && !sdaS && sdaP_q;
    assign stopCond  = sclS && sclP_q && sdaS && !sdaP_q;

    // ---------------------------------------------------------------
    // Serial engine
    // ---------------------------------------------------------------
    i2csw_dev_state_e state_q;
    logic [2:0]       bitCnt_q;
    logic             byteFull_q;
    logic [7:0]       shift_q;
    logic             rw_q;
    logic             sdaOe_q;
    logic [3:0]       ctrlReg_q;
    logic [7:0]       readByte;
    logic             addrMatch;

    // Alert bits are taken live at the moment a read byte is loaded
    assign readByte  = {~alertNS, ctrlReg_q}; // R5 R12 R13 R14 R16
    assign addrMatch = (shift_q[7:1] == {ADDR_FIXED_HI, addrHiS, addrLoS}); // R19

    always_ff @(posedge clk) begin
        if (clear) begin
            state_q    <= DEV_IDLE; // R9 R17
            bitCnt_q   <= 3'h0;
            byteFull_q <= 1'b0;
            shift_q    <= 8'h00;
            rw_q       <= 1'b0;
            sdaOe_q    <= 1'b0;
        end else if (startCond) begin
            state_q    <= DEV_ADDR; // R1
            bitCnt_q   <= 3'h0;
            byteFull_q <= 1'b0;
            sdaOe_q    <= 1'b0;
        end else if (stopCond) begin
            state_q    <= DEV_IDLE;
            sdaOe_q    <= 1'b0;
        end else begin
            case (state_q)
                DEV_ADDR, DEV_WR: begin
                    if (sclRise) begin
                        shift_q  <= {shift_q[6:0], sdaS};
                        bitCnt_q <= bitCnt_q + 3'h1;
                        if (bitCnt_q == 3'h7) begin
                            byteFull_q <= 1'b1;
                        end
                    end else if (sclFall && byteFull_q) begin
                        byteFull_q <= 1'b0;
                        if (state_q == DEV_WR) begin
                            state_q <= DEV_WACK;
                            sdaOe_q <= 1'b1; // R18
                        end else if (addrMatch) begin
                            state_q <= DEV_AACK;
                            rw_q    <= shift_q[0]; // R2
                            sdaOe_q <= 1'b1; // R18
                        end else begin
                            state_q <= DEV_IDLE; // R19
                        end
                    end
                end
                DEV_AACK: begin
                    if (sclFall) begin
                        bitCnt_q <= 3'h0;
                        if (rw_q == RW_READ) begin
                            state_q <= DEV_RD; // R2
                            shift_q <= readByte; // R13
                            sdaOe_q <= !readByte[7];
                        end else begin
                            state_q <= DEV_WR; // R3
                            sdaOe_q <= 1'b0;
                        end
                    end
                end
                DEV_WACK: begin
                    if (sclFall) begin
                        state_q <= DEV_WR; // R4
                        sdaOe_q <= 1'b0;
                    end
                end
                DEV_RD: begin
                    if (sclFall) begin
                        shift_q  <= {shift_q[6:0], 1'b0};
                        bitCnt_q <= bitCnt_q + 3'h1;
                        if (bitCnt_q == 3'h7) begin
                            state_q <= DEV_RACK;
                            sdaOe_q <= 1'b0;
                        end else begin
                            sdaOe_q <= !shift_q[6];
                        end
                    end
                end
                DEV_RACK: begin
                    // A master that withholds its acknowledge ends the read
                    if (sclRise && sdaS) begin
                        state_q <= DEV_IDLE;
                    end else if (sclFall) begin
                        state_q <= DEV_RD;
                        shift_q <= readByte; // R13
                        sdaOe_q <= !readByte[7];
                    end
                end
                default: begin
                    state_q <= DEV_IDLE;
                end
            endcase
        end
    end

    assign link.sdaDevOut = 1'b0;
    assign link.sdaDevOe  = sdaOe_q;

    // ---------------------------------------------------------------
    // Control register and channel connection
    // ---------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (clear) begin
            ctrlReg_q <= CTRL_RESET; // R9 R17
        end else if (!startCond && !stopCond && state_q == DEV_WR && sclFall
                     && byteFull_q) begin
            ctrlReg_q <= shift_q[3:0]; // R3 R4 R20
        end
    end

    // Connecting only at STOP keeps every downstream line idle high at hook-up
    always_ff @(posedge clk) begin
        if (clear) begin
            activeChan_q <= CTRL_RESET; // R9 R17
        end else if (stopCond) begin
            activeChan_q <= ctrlReg_q; // R6 R7 R8
        end
    end

    // ---------------------------------------------------------------
    // Alert output
    // ---------------------------------------------------------------
    // Not gated by channel selection or by the reset pin
    always_ff @(posedge clk) begin
        if (reset) begin
            alertOutOe <= 1'b0;
        end else begin
            alertOutOe <= !(&alertNS); // R10 R11
        end
    end

    assign alertOut = 1'b0;
endmodule
`default_nettype wire

// ===== core/i2csw_host.sv
// Serial-bus master that writes or reads the switch control register
`timescale 1ns/100ps
`default_nettype none
module i2csw_host
    import i2csw_pkg::*;
#(
    parameter int QUARTER_CYC = SCL_QUARTER_CYC
) (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       reset,
    // Link to the switch
    i2csw_if.host           link,
    // Software port
    input  wire logic [1:0] regAddr,
    input  wire logic [7:0] regWdata,
    input  wire logic       regWrite,
    input  wire logic       regRead,
    output logic      [7:0] regRdata_q
);
    // ---------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------
    logic [6:0]       slave_q;
    logic [7:0]       txData_q;
    logic [7:0]       rxData_q;
    logic             readOp_q;
    logic             busy_q;
    logic             nack_q;
    logic             go;
    i2csw_hst_state_e state_q;

    assign go = regWrite && regAddr == HREG_CMD && regWdata[CMD_GO_BIT] && !busy_q;

    always_ff @(posedge clk) begin
        if (reset) begin
            slave_q  <= 7'h00;
            txData_q <= 8'h00;
        end else if (regWrite && regAddr == HREG_SLAVE) begin
            slave_q  <= regWdata[6:0];
        end else if (regWrite && regAddr == HREG_DATA) begin
            txData_q <= regWdata;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            regRdata_q <= 8'h00;
        end else if (regRead) begin
            case (regAddr)
                HREG_SLAVE: regRdata_q <= {1'b0, slave_q};
                HREG_DATA:  regRdata_q <= rxData_q;
                HREG_STAT:  regRdata_q <= {6'h00, nack_q, busy_q};
                default:    regRdata_q <= 8'h00;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Bus engine
    // ---------------------------------------------------------------
    // Clock stretching is not supported; the switch never stretches
    logic [15:0] qCnt_q;
    logic [1:0]  phase_q;
    logic        tick;
    logic [3:0]  bitCnt_q;
    logic        byteIdx_q;
    logic [7:0]  shift_q;
    logic        sclOe_q;
    logic        sdaOe_q;
    logic        sdaS;
    logic        masterRx;

    i2csw_sync #(.WIDTH(1), .INIT(1'b1)) u_sync (
        .clk       (clk),
        .reset     (reset),
        .pinIn     (link.sdaLine),
        .syncOut_q (sdaS)
    );

    assign tick     = (qCnt_q == 16'(QUARTER_CYC - 1));
    assign masterRx = readOp_q && byteIdx_q;

    always_ff @(posedge clk) begin
        if (reset || go || tick) begin
            qCnt_q <= 16'h0000;
        end else begin
            qCnt_q <= qCnt_q + 16'h0001;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_q   <= HST_IDLE;
            phase_q   <= 2'h0;
            busy_q    <= 1'b0;
            nack_q    <= 1'b0;
            readOp_q  <= 1'b0;
            bitCnt_q  <= 4'h0;
            byteIdx_q <= 1'b0;
            shift_q   <= 8'h00;
            rxData_q  <= 8'h00;
            sclOe_q   <= 1'b0;
            sdaOe_q   <= 1'b0;
        end else if (go) begin
            state_q   <= HST_START;
            phase_q   <= 2'h0;
            busy_q    <= 1'b1;
            nack_q    <= 1'b0;
            readOp_q  <= regWdata[CMD_READ_BIT];
            bitCnt_q  <= 4'h0;
            byteIdx_q <= 1'b0;
            shift_q   <= {slave_q, regWdata[CMD_READ_BIT]}; // R1 R2
        end else if (tick && state_q != HST_IDLE) begin
            phase_q <= phase_q + 2'h1;
            case (state_q)
                HST_START: begin
                    if (phase_q == 2'h0) begin
                        sdaOe_q <= 1'b1;
                    end else if (phase_q == 2'h1) begin
                        sclOe_q <= 1'b1;
                        state_q <= HST_BIT;
                        phase_q <= 2'h0;
                    end
                end
                HST_BIT: begin
                    case (phase_q)
                        2'h0: sdaOe_q <= bitCnt_q < 4'h8 && !masterRx && !shift_q[7];
                        2'h1: sclOe_q <= 1'b0;
                        2'h2: begin
                            if (bitCnt_q < 4'h8) begin
                                shift_q <= {shift_q[6:0], sdaS};
                            end else if (!masterRx) begin
                                nack_q <= sdaS; // R18
                            end
                        end
                        default: begin
                            sclOe_q <= 1'b1;
                            if (bitCnt_q == 4'h8) begin
                                bitCnt_q <= 4'h0;
                                if (masterRx) begin
                                    rxData_q <= shift_q;
                                end
                                if (byteIdx_q || nack_q) begin
                                    state_q <= HST_STOP;
                                end else begin
                                    byteIdx_q <= 1'b1;
                                    shift_q   <= readOp_q ? 8'hFF : txData_q; // R3
                                end
                            end else begin
                                bitCnt_q <= bitCnt_q + 4'h1;
                            end
                        end
                    endcase
                end
                HST_STOP: begin
                    case (phase_q)
                        2'h0: sdaOe_q <= 1'b1;
                        2'h1: sclOe_q <= 1'b0;
                        2'h2: sdaOe_q <= 1'b0;
                        default: begin
                            busy_q  <= 1'b0;
                            state_q <= HST_IDLE;
                        end
                    endcase
                end
                default: state_q <= HST_IDLE;
            endcase
        end
    end

    assign link.sclHostOut = 1'b0;
    assign link.sclHostOe  = sclOe_q;
    assign link.sdaHostOut = 1'b0;
    assign link.sdaHostOe  = sdaOe_q;
endmodule
`default_nettype wire

// ===== tb/i2csw_assertions.sv
// Concurrent checks on the two-wire link and the switch pins
`timescale 1ns/100ps
`default_nettype none
module i2csw_assertions
    import i2csw_pkg::*;
(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              reset,
    // Link wires and drivers
    input  wire logic              sclLine,
    input  wire logic              sdaLine,
    input  wire logic              sdaDevOe,
    input  wire logic              sclHostOe,
    input  wire logic              sdaHostOe,
    // Switch pins
    input  wire logic              extResetN,
    input  wire logic [3:0]        alertN,
    input  wire logic              alertOutOe,
    input  wire logic [CHAN_N-1:0] activeChan_q
);
    logic [6:0] lowCnt_q;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // Saturating, so a long pin pulse cannot wrap back under the limit
    always_ff @(posedge clk) begin
        if (reset || extResetN) begin
            lowCnt_q <= 7'h00;
        end else if (lowCnt_q != 7'h7F) begin
            lowCnt_q <= lowCnt_q + 7'h01;
        end
    end
    alert_low_a : assert property ((alertN != 4'hF) [*5] |-> alertOutOe)
        else $error("alert output not pulled low");
    alert_high_a : assert property ((alertN == 4'hF) [*5] |-> !alertOutOe)
        else $error("alert output low with no alert");
    chan_at_stop_a : assert property ($changed(activeChan_q) |-> sclLine && sdaLine || !extResetN)
        else $error("channels changed outside a stop");
    ack_in_low_a : assert property ($rose(sdaDevOe) |-> !sclLine [*4])
        else $error("data driven while clock high");
    sda_steady_a : assert property (sclLine && $past(sclLine) |-> $stable(sdaDevOe))
        else $error("data changed during clock high");
    reset_idle_a : assert property ($fell(reset) |-> !sdaDevOe && !sclHostOe && !sdaHostOe
        && activeChan_q == 4'h0)
        else $error("not idle after reset");
    ext_clear_a : assert property (lowCnt_q >= 7'h46 |-> activeChan_q == 4'h0)
        else $error("reset pin did not clear channels");
    start_clock_a : assert property ($fell(sdaLine) && sclLine && $past(sclLine)
        |-> ##[1:12] !sclLine)
        else $error("start not followed by clocking");
endmodule
`default_nettype wire

// ===== tb/i2csw_tb.sv
// Bench: bus master and channel switch joined over the two-wire link
`timescale 1ns/100ps
`default_nettype none
module i2csw_tb
    import i2csw_pkg::*;
;
    localparam logic [6:0] OWN_ADDR = {ADDR_FIXED_HI, 2'b01};
    logic              clk = 1'b0;
    logic              reset = 1'b1;
    logic [1:0]        regAddr = 2'h0;
    logic [7:0]        regWdata = 8'h00;
    logic              regWrite = 1'b0;
    logic              regRead = 1'b0;
    logic [7:0]        regRdata_q;
    logic              extResetN = 1'b1;
    logic [3:0]        alertN = 4'hF;
    logic              alertOut;
    logic              alertOutOe;
    logic [CHAN_N-1:0] activeChan_q;
    logic [7:0]        rx;
    logic              nack;
    logic [3:0]        pat [6] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h6, 4'hF};
    int                n_errors = 0;
    int                num_checks = 0;
    i2csw_if i2csw_if_i ();
    always #4 clk = ~clk;
    // Short quarter period keeps the run brief
    i2csw_host #(.QUARTER_CYC(8)) i2csw_host_i (
        .clk(clk), .reset(reset), .link(i2csw_if_i), .regAddr(regAddr), .regWdata(regWdata),
        .regWrite(regWrite), .regRead(regRead), .regRdata_q(regRdata_q));
    i2csw_device i2csw_device_i (
        .clk(clk), .reset(reset), .link(i2csw_if_i), .addr_select_pin_lo(1'b1),
        .addr_select_pin_hi(1'b0), .extResetN(extResetN), .chan0_alert_in_n(alertN[0]),
        .chan1_alert_in_n(alertN[1]), .chan2_alert_in_n(alertN[2]),
        .chan3_alert_in_n(alertN[3]), .alertOut(alertOut), .alertOutOe(alertOutOe),
        .activeChan_q(activeChan_q));
    i2csw_assertions i2csw_assertions_i (
        .clk(clk), .reset(reset), .sclLine(i2csw_if_i.sclLine), .sdaLine(i2csw_if_i.sdaLine),
        .sdaDevOe(i2csw_if_i.sdaDevOe), .sclHostOe(i2csw_if_i.sclHostOe),
        .sdaHostOe(i2csw_if_i.sdaHostOe), .extResetN(extResetN), .alertN(alertN),
        .alertOutOe(alertOutOe), .activeChan_q(activeChan_q));
    // ------------------------------------------------------------
    // Access tasks
    // ------------------------------------------------------------
    task automatic end_of_test();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        regAddr  <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask
    task automatic rd(input logic [1:0] a, output logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk);
        regRead <= 1'b0;
        @(posedge clk);
        d = regRdata_q;
    endtask
    task automatic xfer(input logic [6:0] sa, input logic rdOp, input logic [7:0] d);
        logic [7:0] st;
        int         n;
        wr(HREG_SLAVE, {1'b0, sa});
        wr(HREG_DATA, d);
        wr(HREG_CMD, rdOp ? 8'h03 : 8'h01);
        repeat (4) @(posedge clk);
        n = 0;
        st = 8'h01;
        while (st[0] !== 1'b0 && n < 2000) begin
            rd(HREG_STAT, st);
            n++;
        end
        chk("master busy", 8'h00, {7'h00, st[0]});
        nack = st[1];
        rd(HREG_DATA, rx);
    endtask
    task automatic wrChk(input logic [7:0] v, input logic [3:0] chan);
        xfer(OWN_ADDR, 1'b0, v);
        chk("write nack", 8'h00, {7'h00, nack});
        chk("channels", {4'h0, chan}, {4'h0, activeChan_q});
    endtask
    task automatic rdChk(input logic [7:0] exp);
        xfer(OWN_ADDR, 1'b1, 8'h00);
        chk("read nack", 8'h00, {7'h00, nack});
        chk("read byte", exp, rx);
    endtask
    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        chk("channels after reset", 8'h00, {4'h0, activeChan_q});
        rdChk(8'h00);
        wrChk(8'hA5, 4'h5);
        rdChk(8'h05);
        foreach (pat[i]) begin
            wrChk({~pat[i], pat[i]}, pat[i]);
            rdChk({4'h0, pat[i]});
        end
        xfer({ADDR_FIXED_HI, 2'b11}, 1'b0, 8'h03);
        chk("nack other pins", 8'h01, {7'h00, nack});
        xfer({~ADDR_FIXED_HI, 2'b01}, 1'b0, 8'h03);
        chk("nack fixed bits", 8'h01, {7'h00, nack});
        chk("channels kept", 8'h0F, {4'h0, activeChan_q});
        wrChk(8'h01, 4'h1);
        for (int i = 0; i < 4; i++) begin
            alertN <= ~(4'h1 << i);
            repeat (8) @(posedge clk);
            chk("alert pin", 8'h02, {6'h00, alertOutOe, alertOut});
            rdChk({4'h1 << i, 4'h1});
        end
        alertN <= 4'b1001;
        rdChk(8'h61);
        wrChk(8'h06, 4'h6);
        alertN <= 4'hF;
        repeat (8) @(posedge clk);
        chk("alert pin idle", 8'h00, {6'h00, alertOutOe, alertOut});
        rdChk(8'h06);
        wrChk(8'h03, 4'h3);
        extResetN <= 1'b0;
        repeat (30) @(posedge clk);
        extResetN <= 1'b1;
        repeat (8) @(posedge clk);
        chk("channels short pulse", 8'h03, {4'h0, activeChan_q});
        extResetN <= 1'b0;
        repeat (80) @(posedge clk);
        extResetN <= 1'b1;
        repeat (8) @(posedge clk);
        chk("channels pin reset", 8'h00, {4'h0, activeChan_q});
        rdChk(8'h00);
        end_of_test();
    end
    // Whole run needs about 17000 cycles
    initial begin
        repeat (100000) @(posedge clk);
        n_errors++;
        end_of_test();
    end
endmodule
`default_nettype wire
